// ---- core/tfr_pkg.sv ----
// Package for the timer forced-reload and suspend-sync block.
// Assumes a byte-wide special register port with page decode done outside.
`default_nettype none
package tfr_pkg;

  // Register address and field layout
  localparam logic [7:0] TFR_CTRL_ONE_ADDR = 8'hff;
  localparam int TFR_SEL_LSB = 5;
  localparam int TFR_SYNC_BIT = 4;
  localparam int TFR_CAPSEL_LSB = 0;
  localparam logic [2:0] TFR_SEL_RESET = 3'h0;
  localparam logic [2:0] TFR_CAPSEL_RESET = 3'h0;

  // Forced reload selector codes
  localparam logic [2:0] TFR_SEL_I2C_CLOCK = 3'h0;
  localparam logic [2:0] TFR_SEL_LOGIC_ZERO = 3'h1;
  localparam logic [2:0] TFR_SEL_LOGIC_TWO = 3'h2;
  localparam logic [2:0] TFR_SEL_NONE = 3'h3;

  // Resync time after foreign wake-up, in timer clocks
  localparam int TFR_SYNC_CLOCKS = 3;
  localparam logic [1:0] TFR_SYNC_COUNT = 2'(TFR_SYNC_CLOCKS);

  // Register port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tfr_req_s;

  // Forcing sources, as seen at the pins of the block
  typedef struct packed {
    logic i2c_timeout_en;
    logic i2c_target_clock_line_source;
    logic logic_unit_zero_sync_output;
    logic logic_unit_two_sync_output;
  } tfr_src_s;

endpackage
`default_nettype wire

// ---- core/tfr_timer_forced_reload.sv ----
// Forced reload selection and suspend-sync status for the timer.
// Assumes overflow and foreign wake-up come from logic on clk; forcing
// sources arrive from other domains and are synchronised here.
// Register side is a byte-wide port; the page is decoded outside.
`timescale 1ns/1ns
`default_nettype none
module tfr_timer_forced_reload (
  input wire logic clk,
  input wire logic reset,
  input wire tfr_pkg::tfr_req_s req,
  output logic [7:0] rdata,
  input wire tfr_pkg::tfr_src_s src,
  input wire logic overflow,
  input wire logic foreign_wakeup,
  output logic reload,
  output logic [2:0] capture_input_selector,
  output logic suspend_sync_status
);
  import tfr_pkg::*;

  // ****************************************************
  // Input synchronisers
  // ****************************************************
  // Two flops per source cost two cycles of forcing latency,
  // but keep a metastable pin level out of the selector
  tfr_src_s sync1_reg, sync2_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= src;
      sync2_reg <= sync1_reg;
    end
  end

  // ****************************************************
  // Control register
  // ****************************************************
  logic [2:0] sel_reg, sel_next;
  logic [2:0] capsel_reg, capsel_next;
  logic [1:0] sync_cnt_reg, sync_cnt_next;
  logic [7:0] rdata_reg, rdata_next;
  logic reload_reg, reload_next;
  logic sync_reg, sync_next;
  logic hit;
  logic force_level;
  // Reserved bit 3 is not stored; it always reads back as zero

  // ****************************************************
  // Forcing selection
  // ****************************************************
  // Selector decode, used for both reload and its check
  function automatic logic pick_force(input logic [2:0] sel,
                                      input tfr_src_s s);
    logic f;
    f = 1'b0;
    unique case (sel)
      TFR_SEL_I2C_CLOCK:
        f = s.i2c_timeout_en & s.i2c_target_clock_line_source;
      TFR_SEL_LOGIC_ZERO: f = s.logic_unit_zero_sync_output;
      TFR_SEL_LOGIC_TWO: f = s.logic_unit_two_sync_output;
      TFR_SEL_NONE: f = 1'b0;
      default: f = 1'b0; // Codes 4..7 undefined: no forcing
    endcase
    return f;
  endfunction

  // Only the byte address is seen here
  assign hit = (req.addr == TFR_CTRL_ONE_ADDR);
  assign force_level = pick_force(sel_reg, sync2_reg);

  // ****************************************************
  // Next state
  // ****************************************************
  // Next-state for register, sync counter and reload
  always_comb begin
    sel_next = sel_reg;
    capsel_next = capsel_reg;
    sync_cnt_next = sync_cnt_reg;
    // Flag is hardware owned; writes to that bit are ignored
    if (req.wr && hit) begin
      sel_next = req.wdata[TFR_SEL_LSB +: 3];
      capsel_next = req.wdata[TFR_CAPSEL_LSB +: 3];
    end
    // restart resync window
    // A new wake-up wins over the count-down and restarts it
    if (foreign_wakeup) begin
      sync_cnt_next = TFR_SYNC_COUNT;
    end else if (sync_cnt_reg != 2'h0) begin
      sync_cnt_next = sync_cnt_reg - 2'h1;
    end
    // Flag lasts the full worst-case three clocks, so software
    // may wait a little longer than strictly needed
    // clear only when count done
    sync_next = (sync_cnt_next != 2'h0);
    reload_next = overflow | force_level;
    rdata_next = 8'h00;
    if (req.rd && hit) begin
      rdata_next = {sel_reg, sync_reg, 1'b0, capsel_reg};
    end
  end

  // ****************************************************
  // Register stage
  // ****************************************************
  // Registers only
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_reg <= TFR_SEL_RESET;
      capsel_reg <= TFR_CAPSEL_RESET;
      sync_cnt_reg <= 2'h0;
      sync_reg <= 1'b0;
      reload_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      sel_reg <= sel_next;
      capsel_reg <= capsel_next;
      sync_cnt_reg <= sync_cnt_next;
      sync_reg <= sync_next;
      reload_reg <= reload_next;
      rdata_reg <= rdata_next;
    end
  end

  // ****************************************************
  // Outputs
  // ****************************************************
  // Every output comes straight from a flop, no decode after it
  assign rdata = rdata_reg;
  assign reload = reload_reg;
  assign capture_input_selector = capsel_reg;
  assign suspend_sync_status = sync_reg;

  // ****************************************************
  // Checks
  // ****************************************************
  // Each property looks at a registered output from one edge after
  // its cause; all run on clk under the synchronous reset
  // none code never forces
  a_none_no_force: assert property (
    @(posedge clk) disable iff (reset)
    (sel_reg == TFR_SEL_NONE && !overflow) |=> !reload)
    else $error("reload without cause in none mode");

  a_upper_no_force: assert property (
    @(posedge clk) disable iff (reset)
    (sel_reg > TFR_SEL_NONE && !overflow) |=> !reload)
    else $error("reload without cause on unused code");

  a_ovf_reloads: assert property (
    @(posedge clk) disable iff (reset)
    overflow |=> reload)
    else $error("overflow did not reload");

  a_lu0_force: assert property (
    @(posedge clk) disable iff (reset)
    (sel_reg == TFR_SEL_LOGIC_ZERO && sync2_reg.logic_unit_zero_sync_output)
    |=> reload)
    else $error("logic unit zero did not force reload");

  a_lu2_force: assert property (
    @(posedge clk) disable iff (reset)
    (sel_reg == TFR_SEL_LOGIC_TWO && sync2_reg.logic_unit_two_sync_output)
    |=> reload)
    else $error("logic unit two did not force reload");

  a_i2c_gate: assert property (
    @(posedge clk) disable iff (reset)
    (sel_reg == TFR_SEL_I2C_CLOCK && !overflow
     && !sync2_reg.i2c_timeout_en) |=> !reload)
    else $error("clock line forced reload without timeout");

  a_i2c_force: assert property (
    @(posedge clk) disable iff (reset)
    (sel_reg == TFR_SEL_I2C_CLOCK && sync2_reg.i2c_timeout_en
     && sync2_reg.i2c_target_clock_line_source) |=> reload)
    else $error("clock line high did not force reload");

  a_i2c_no_clock: assert property (
    @(posedge clk) disable iff (reset)
    (sel_reg == TFR_SEL_I2C_CLOCK && !overflow
     && !sync2_reg.i2c_target_clock_line_source) |=> !reload)
    else $error("clock line low forced reload");

  a_reload_cause: assert property (
    @(posedge clk) disable iff (reset)
    reload |-> $past(overflow) || $past(force_level))
    else $error("reload without sampled cause");

  a_sync_hold: assert property (
    @(posedge clk) disable iff (reset)
    foreign_wakeup |=> suspend_sync_status[*3])
    else $error("sync flag not held after wake-up");

  a_sync_clear: assert property (
    @(posedge clk) disable iff (reset)
    (foreign_wakeup ##1 !foreign_wakeup[*3]) |=> !suspend_sync_status)
    else $error("sync flag stuck after resync");

  a_flag_quiet: assert property (
    @(posedge clk) disable iff (reset)
    (!foreign_wakeup && sync_cnt_reg == 2'h0) |=> !suspend_sync_status)
    else $error("sync flag set with no resync pending");
endmodule
`default_nettype wire

// ---- dv/tfr_timer_forced_reload_test.sv ----
// Self-checking bench for the forced-reload and suspend-sync block.
// Assumes the block alone on one clock, every source driven from here.
`timescale 1ns/1ns
`default_nettype none
module tfr_timer_forced_reload_test;
  import tfr_pkg::*;
  // ***************
  // Bench signals
  // ***************
  logic clk = 0, reset = 1, overflow = 0, foreign_wakeup = 0;
  logic reload, suspend_sync_status;
  logic [7:0] rdata;
  logic [2:0] capture_input_selector;
  tfr_req_s req = '0;
  tfr_src_s src = '0;
  int bad_count = 0, checked = 0;
  tfr_timer_forced_reload i_tfr_timer_forced_reload (.clk(clk),
    .reset(reset), .req(req), .rdata(rdata), .src(src),
    .overflow(overflow), .foreign_wakeup(foreign_wakeup), .reload(reload),
    .capture_input_selector(capture_input_selector),
    .suspend_sync_status(suspend_sync_status));
  // Free-running 4 ns clock
  always #2 clk = ~clk;
  // Compare; outputs are sampled at the falling edge, well settled
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access; rdata is valid right after the sampling edge
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    @(negedge clk);
  endtask
  // Reset value, read-only bits, unmapped address
  task automatic t_regs;
    acc(0, 8'hff, 8'h00); chk(rdata, 8'h00);
    acc(1, 8'hff, 8'hff); chk(capture_input_selector, 8'h07);
    acc(0, 8'hff, 8'h00); chk(rdata, 8'he7);
    acc(0, 8'hfe, 8'h00); chk(rdata, 8'h00);
  endtask
  // Hold one source pattern; synchroniser delay is covered by 5 edges
  task automatic t_force(input logic [2:0] sel, input tfr_src_s s,
    input logic exp);
    acc(1, 8'hff, {sel, 5'h00});
    @(posedge clk);
    src <= s;
    repeat (5) @(posedge clk);
    @(negedge clk); chk(reload, exp);
    @(posedge clk);
    src <= '0;
    repeat (5) @(posedge clk);
    @(negedge clk); chk(reload, 0);
  endtask
  // Single overflow gives a single reload cycle
  task automatic t_overflow;
    acc(1, 8'hff, 8'h60);
    @(posedge clk);
    overflow <= 1;
    @(posedge clk);
    overflow <= 0;
    @(negedge clk); chk(reload, 1);
    @(negedge clk); chk(reload, 0);
  endtask
  // Foreign wake-up: flag for three clocks, then clear
  task automatic t_wakeup;
    @(posedge clk);
    foreign_wakeup <= 1;
    @(posedge clk);
    foreign_wakeup <= 0;
    repeat (3) begin
      @(negedge clk); chk(suspend_sync_status, 1);
    end
    @(negedge clk); chk(suspend_sync_status, 0);
    // touch the register only once the flag is clear
    acc(1, 8'hff, 8'h45); chk(capture_input_selector, 8'h05);
  endtask
  // Mid-run reset, coinciding with a wake-up, clears all state
  task automatic t_reset;
    acc(1, 8'hff, 8'h65); chk(capture_input_selector, 8'h05);
    @(posedge clk);
    foreign_wakeup <= 1;
    reset <= 1;
    @(posedge clk);
    foreign_wakeup <= 0;
    reset <= 0;
    @(negedge clk); chk(suspend_sync_status, 0);
    chk(capture_input_selector, 8'h00);
    chk(reload, 0);
    acc(0, 8'hff, 8'h00); chk(rdata, 8'h00);
  endtask
  // Verdict and end of run
  task automatic summarize;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Watchdog; the whole sequence needs well under 1 us
  initial begin
    #20000;
    bad_count++;
    summarize();
  end
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    t_regs();
    t_force(3'h0, 4'b0100, 0);
    t_force(3'h0, 4'b1100, 1);
    t_force(3'h1, 4'b0010, 1);
    t_force(3'h1, 4'b0001, 0);
    t_force(3'h2, 4'b0001, 1);
    t_force(3'h2, 4'b1110, 0);
    t_force(3'h3, 4'b1111, 0);
    t_force(3'h7, 4'b1111, 0);
    t_overflow();
    t_wakeup();
    t_reset();
    summarize();
  end
endmodule
`default_nettype wire
